// *** testbench.sv ***
`default_nettype none
// ==========================================================
// register-level test of the serial frame core
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import uftrx_pkg::*;
	localparam int LIMIT = 20000;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic rx_pin;
	logic tx_pin;
	logic irq_request;
	logic [7:0] rv;
	// parity bit by type code for seven data bits holding three ones
	logic [3:0] par_exp = 4'h5;
	time dt;
	int checks = 0;
	int miscompares = 0;
	int cycles = 0;
	uftrx_core dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .rx_pin, .tx_pin, .irq_request);
	uftrx_remote remote_u (.sys_clk, .tx_pin, .rx_pin);
	always #5 sys_clk = ~sys_clk;
	// ==========================================================
	// hang guard and closing report
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	// ==========================================================
	// bus tasks; each ends one edge after its strobe drops
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask : rd
	task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk({1'b0, d}, {1'b0, exp});
	endtask : rchk
	task automatic wait_tx(input int n);
		for (int k = 0; k < 4000 && remote_u.got_q.size() < n; k++)
			@(posedge sys_clk);
		repeat (40) @(posedge sys_clk);
		chk(9'(remote_u.got_q.size()), 9'(n));
	endtask : wait_tx
	task automatic clear_tx;
		remote_u.got_q.delete();
		remote_u.t_q.delete();
	endtask : clear_tx
	// ==========================================================
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rchk(ADDR_STATUS, 8'h0B);
		rchk(ADDR_CTRL_ONE, 8'h00);
		rchk(ADDR_CTRL_TWO, 8'h00);
		rchk(ADDR_DIV_HIGH, 8'h00);
		rchk(ADDR_DIV_LOW, 8'h00);
		rchk(ADDR_RX_COUNT, 8'h00);
		wr(3'h7, 8'hFF);
		wr(ADDR_STATUS, 8'h00);
		rchk(3'h7, 8'h00);
		rchk(ADDR_STATUS, 8'h0B);
		$display("reset values done");
		// data first, enable later; a third byte is refused
		wr(ADDR_CTRL_ONE, 8'h80);
		rd(ADDR_STATUS, rv);
		wr(ADDR_DATA, 8'h5A);
		repeat (40) @(posedge sys_clk);
		chk(9'(tx_pin), 9'h001);
		wr(ADDR_CTRL_TWO, 8'h80);
		repeat (20) @(posedge sys_clk);
		rd(ADDR_STATUS, rv);
		wr(ADDR_DATA, 8'hC3);
		wr(ADDR_DATA, 8'h11);
		rchk(ADDR_STATUS, 8'h08);
		wait_tx(2);
		chk(remote_u.got_q[0], 9'h05A);
		chk(remote_u.got_q[1], 9'h0C3);
		repeat (160) @(posedge sys_clk);
		chk(9'(remote_u.got_q.size()), 9'h002);
		rchk(ADDR_STATUS, 8'h0B);
		$display("transmit order done");
		// every parity type, seven data bits under the parity bit
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_CTRL_ONE, 8'hA0 | 8'(p << 3));
			clear_tx();
			rd(ADDR_STATUS, rv);
			wr(ADDR_DATA, 8'h15);
			wait_tx(1);
			chk(remote_u.got_q[0], {1'b0, par_exp[p], 7'h15});
		end
		$display("parity done");
		// nine bits, two stop_count_select, back to back
		wr(ADDR_CTRL_ONE, 8'hC5);
		remote_u.nbits = 9;
		clear_tx();
		rd(ADDR_STATUS, rv);
		wr(ADDR_DATA, 8'hAA);
		rchk(ADDR_STATUS, 8'h09);
		wr(ADDR_DATA, 8'h55);
		wait_tx(2);
		chk(remote_u.got_q[0], 9'h1AA);
		chk(remote_u.got_q[1], 9'h155);
		dt = remote_u.t_q[1] - remote_u.t_q[0];
		chk(9'(dt >= 1920 && dt <= 1950), 9'h001);
		$display("nine bit done");
		// transmitter switched off mid-frame
		wr(ADDR_CTRL_ONE, 8'h80);
		remote_u.nbits = 8;
		rd(ADDR_STATUS, rv);
		wr(ADDR_DATA, 8'h00);
		repeat (60) @(posedge sys_clk);
		wr(ADDR_CTRL_TWO, 8'h00);
		repeat (2) @(posedge sys_clk);
		chk(9'(tx_pin), 9'h001);
		rchk(ADDR_STATUS, 8'h0B);
		repeat (200) @(posedge sys_clk);
		chk(9'(remote_u.stop_bad), 9'h000);
		$display("abort done");
		// receive: address word with noise, then parity and stop faults
		wr(ADDR_CTRL_TWO, 8'h55);
		remote_u.send(9'h081, 8, 1'b1, 2);
		rchk(ADDR_RX_COUNT, 8'h81);
		chk(9'(irq_request), 9'h001);
		rd(ADDR_STATUS, rv);
		chk(9'(rv), 9'h04F);
		rchk(ADDR_DATA, 8'h81);
		rchk(ADDR_STATUS, 8'h0B);
		chk(9'(irq_request), 9'h000);
		wr(ADDR_CTRL_ONE, 8'hA0);
		remote_u.send(9'h001, 8, 1'b0, 99);
		rchk(ADDR_STATUS, 8'hAF);
		rchk(ADDR_DATA, 8'h01);
		wr(ADDR_CTRL_ONE, 8'hC0);
		remote_u.send(9'h155, 9, 1'b1, 99);
		rchk(ADDR_CTRL_ONE, 8'hC2);
		rd(ADDR_STATUS, rv);
		rchk(ADDR_DATA, 8'h55);
		$display("receive done");
		// trigger code 00 needs four bytes; the fifth overruns
		wr(ADDR_CTRL_ONE, 8'h80);
		wr(ADDR_CTRL_TWO, 8'h44);
		for (int i = 0; i < 5; i++) begin
			remote_u.send(9'(8'h10 + i), 8, 1'b1, 99);
			rd(ADDR_STATUS, rv);
			chk(9'(rv & 8'h1F), {4'h0, i == 4, 1'b1, i >= 3, 2'h3});
		end
		chk(9'(irq_request), 9'h001);
		rchk(ADDR_RX_COUNT, 8'h04);
		for (int i = 0; i < 4; i++)
			rchk(ADDR_DATA, 8'(8'h10 + i));
		rchk(ADDR_RX_COUNT, 8'h00);
		$display("buffer done");
		// break held over two characters, then released
		clear_tx();
		wr(ADDR_CTRL_TWO, 8'hA8);
		repeat (100) @(posedge sys_clk);
		chk(9'(tx_pin), 9'h000);
		chk(9'(irq_request), 9'h000);
		repeat (300) @(posedge sys_clk);
		wr(ADDR_CTRL_TWO, 8'h88);
		repeat (20) @(posedge sys_clk);
		chk(9'(tx_pin), 9'h000);
		repeat (40) @(posedge sys_clk);
		chk(9'(tx_pin), 9'h001);
		chk(9'(irq_request), 9'h001);
		chk(9'(remote_u.stop_bad), 9'h001);
		rchk(ADDR_STATUS, 8'h0B);
		$display("break done");
		complete_run();
	end
endmodule : testbench
`default_nettype wire

// *** uftrx_core.sv ***
// Behaviour
// - send 8-bit words, or 9-bit with the top bit from transmit_ninth_bit
// - in 9-bit mode the received top bit goes to receive_ninth_bit
// - transmitter sends one or two stop bits; receiver checks one
// - parity, when on, occupies the word's top bit; odd/even/mark/space
// - with address detection on, the word's top bit marks an address
// - frames go out and come in least significant bit first
// - shift register reloads only after the stop bits are fully sent
// - sending starts only with transmitter on and data loaded
// - clearing transmitter_on mid-frame stop_count_select and resets the transmitter
// - write while idle starts the frame and sets empty flag at once
// - empty flag shows room; data writes blocked while it is low
// - status read then data write clears empty and idle flags
// - transmitter idle flag sets when a frame or break completes
// - break request held over divisor+1 clocks while idle sends a break
// - breaks repeat while requested, then stop bits; no transmit irq
// - receive recovery runs at sixteen ticks per bit
// - each received bit is a majority of three samples
// - after the stop sample the word moves into the buffer if room
// - buffer holds four bytes; a fifth without room sets overrun
// - receive flag sets when buffered bytes reach trigger level; irq with it
// - status read then data read clears the receive flag once below trigger level
// - a break is received as zeros with framing error, then waits high
// - receiver idle is low from start detect until the stop sample
// - trigger codes 00,01,10,11 mean 4,1,2,3 bytes
// - receive count tracks buffered bytes, saturates at 4
// - transmit pin rests high when nothing is sent
`default_nettype none
module uftrx_core (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic rx_pin,
	output logic tx_pin,
	output logic irq_request
);
	import uftrx_pkg::*;

	// ==================================================================
	// word shaping shared by transmit build and receive check
	// parity replaces the top bit and covers the bits below it
	function automatic logic [8:0] uftrx_word(input logic [8:0] w,
			input logic nine, input logic pon, input logic [1:0] pt);
		logic [8:0] m;
		logic p;
		logic [8:0] r;
		m = nine ? {1'b0, w[7:0]} : {2'b00, w[6:0]};
		r = nine ? w : {1'b0, w[7:0]};
		if (pt == PAR_EVEN)
			p = ^m;
		else if (pt == PAR_ODD)
			p = ~^m;
		else
			p = (pt == PAR_MARK);
		if (pon && nine)
			r[8] = p;
		else if (pon)
			r[7] = p;
		return r;
	endfunction : uftrx_word

	// ==================================================================
	// registers
	logic [7:0] ctrl_one;
	logic [7:0] ctrl_two;
	logic [15:0] baud_divisor;
	logic status_seen;
	logic transmit_empty_flag;
	logic transmitter_idle_flag;
	logic receive_available_flag;
	logic overrun_flag;
	logic framing_error_flag;
	logic noise_flag;
	logic parity_error_flag;
	logic receiver_idle_flag;
	logic address_seen;

	wire unit_on = ctrl_one[C1_UNIT_ON];
	wire word_length_select = ctrl_one[C1_WORD_LEN];
	wire parity_on = ctrl_one[C1_PARITY_ON];
	wire [1:0] parity_type_select = ctrl_one[C1_PTYPE_LO +: 2];
	wire stop_count_select = ctrl_one[C1_STOP_CNT];
	wire transmit_ninth_bit = ctrl_one[C1_TX_NINTH];
	wire transmitter_on = ctrl_two[C2_TX_ON];
	wire receiver_on = ctrl_two[C2_RX_ON];
	wire break_request = ctrl_two[C2_BREAK];
	wire addr_detect_on = ctrl_two[C2_ADDR_ON];
	wire [1:0] receive_trigger_level = ctrl_two[C2_TRIG_LO +: 2];
	// clearing the unit holds status, buffer and count in their reset form
	wire clr = rst | ~unit_on;

	// ==================================================================
	// access decode
	wire wr_c1 = reg_write && reg_addr == ADDR_CTRL_ONE;
	wire wr_c2 = reg_write && reg_addr == ADDR_CTRL_TWO;
	wire wr_dh = reg_write && reg_addr == ADDR_DIV_HIGH;
	wire wr_dl = reg_write && reg_addr == ADDR_DIV_LOW;
	wire wr_data = reg_write && reg_addr == ADDR_DATA;
	wire rd_data = reg_read && reg_addr == ADDR_DATA;
	wire rd_stat = reg_read && reg_addr == ADDR_STATUS;
	wire data_ok = wr_data && transmit_empty_flag;
	wire seq_wr = wr_data && status_seen;
	wire seq_rd = rd_data && status_seen;
	wire unit_rise = wr_c1 && reg_wdata[C1_UNIT_ON] && !unit_on;

	// control registers; unit off forces the enables and break low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_one <= CTRL_ONE_RST;
			ctrl_two <= CTRL_TWO_RST;
			baud_divisor <= DIV_RST;
		end else begin
			if (wr_c1)
				ctrl_one <= reg_wdata;
			if (wr_c2)
				ctrl_two <= reg_wdata;
			else if (!unit_on)
				ctrl_two[C2_BREAK +: 3] <= 3'b000;
			if (wr_dh)
				baud_divisor[15:8] <= reg_wdata;
			if (wr_dl)
				baud_divisor[7:0] <= reg_wdata;
		end
	end

	// status access arms the clearing sequence; any data access ends it
	always_ff @(posedge sys_clk) begin
		if (rst)
			status_seen <= 1'b0;
		else if (rd_stat)
			status_seen <= 1'b1;
		else if (wr_data || rd_data)
			status_seen <= 1'b0;
	end

	// ==================================================================
	// oversample tick: one per divisor+1 clocks, sixteen per bit
	logic [15:0] os_cnt;
	wire os_tick = os_cnt == baud_divisor;
	always_ff @(posedge sys_clk) begin
		if (rst || os_tick)
			os_cnt <= 16'h0000;
		else
			os_cnt <= os_cnt + 16'h0001;
	end

	// ==================================================================
	// transmitter
	uftrx_tx_t tx_state;
	logic [3:0] tx_os;
	logic [3:0] tx_idx;
	logic [8:0] tx_shift;
	logic [8:0] tx_hold;
	logic hold_valid;
	logic [15:0] brk_cnt;
	logic brk_armed;

	wire tx_bit_end = os_tick && tx_os == OS_LAST;
	wire [3:0] tx_nbits = word_length_select ? 4'h9 : 4'h8;
	wire [3:0] tx_nstop = stop_count_select ? 4'h2 : 4'h1;
	wire tx_busy = tx_state != UFTRX_T_IDLE;
	wire [8:0] wr_word = uftrx_word({transmit_ninth_bit, reg_wdata},
		word_length_select, parity_on, parity_type_select);
	// a write straight into an idle enabled transmitter starts at once
	wire tx_direct = data_ok && !tx_busy && transmitter_on
		&& !hold_valid && !brk_armed;
	wire tx_from_hold = !tx_busy && transmitter_on && hold_valid
		&& !brk_armed;
	wire tx_brk_go = !tx_busy && transmitter_on && brk_armed;
	wire frame_done = tx_state == UFTRX_T_STOP && tx_bit_end
		&& tx_idx == tx_nstop - 4'h1;
	// dropping the enable mid-frame puts the flags back to reset form
	wire tx_abort = wr_c2 && !reg_wdata[C2_TX_ON] && tx_busy;

	// break request must outlast divisor+1 clocks with the line idle
	always_ff @(posedge sys_clk) begin
		if (clr || !break_request) begin
			brk_cnt <= 16'h0000;
			brk_armed <= 1'b0;
		end else if (transmitter_idle_flag && !brk_armed) begin
			brk_cnt <= brk_cnt + 16'h0001;
			brk_armed <= brk_cnt > baud_divisor;
		end
	end

	// frame sequencer; dropping the enable aborts any frame at once
	always_ff @(posedge sys_clk) begin
		if (clr || !transmitter_on) begin
			tx_state <= UFTRX_T_IDLE;
			tx_os <= 4'h0;
			tx_idx <= 4'h0;
			tx_shift <= 9'h000;
			tx_pin <= 1'b1;
		end else begin
			if (os_tick)
				tx_os <= tx_os + 4'h1;
			case (tx_state)
				UFTRX_T_IDLE: begin
					tx_pin <= 1'b1;
					tx_os <= 4'h0;
					tx_idx <= 4'h0;
					if (tx_brk_go) begin
						tx_state <= UFTRX_T_BREAK;
						tx_pin <= 1'b0;
					end else if (tx_direct || tx_from_hold) begin
						tx_shift <= tx_direct ? wr_word : tx_hold;
						tx_state <= UFTRX_T_START;
						tx_pin <= 1'b0;
					end
				end
				UFTRX_T_START: begin
					if (tx_bit_end) begin
						tx_state <= UFTRX_T_DATA;
						tx_pin <= tx_shift[0];
						tx_shift <= {1'b0, tx_shift[8:1]};
					end
				end
				UFTRX_T_DATA: begin
					if (tx_bit_end && tx_idx == tx_nbits - 4'h1) begin
						tx_state <= UFTRX_T_STOP;
						tx_idx <= 4'h0;
						tx_pin <= 1'b1;
					end else if (tx_bit_end) begin
						tx_idx <= tx_idx + 4'h1;
						tx_pin <= tx_shift[0];
						tx_shift <= {1'b0, tx_shift[8:1]};
					end
				end
				UFTRX_T_STOP: begin
					if (frame_done)
						tx_state <= UFTRX_T_IDLE;
					else if (tx_bit_end)
						tx_idx <= tx_idx + 4'h1;
				end
				UFTRX_T_BREAK: begin
					// start bit plus thirteen zeros, repeated while held
					if (tx_bit_end && tx_idx == BREAK_BITS) begin
						tx_idx <= 4'h1;
						if (!break_request) begin
							tx_state <= UFTRX_T_STOP;
							tx_idx <= 4'h0;
							tx_pin <= 1'b1;
						end
					end else if (tx_bit_end)
						tx_idx <= tx_idx + 4'h1;
				end
				default: tx_state <= UFTRX_T_IDLE;
			endcase
		end
	end

	// holding register and the two transmit flags
	always_ff @(posedge sys_clk) begin
		if (clr) begin
			tx_hold <= 9'h000;
			hold_valid <= 1'b0;
			transmit_empty_flag <= 1'b1;
			transmitter_idle_flag <= 1'b1;
		end else begin
			if (data_ok && !tx_direct) begin
				tx_hold <= wr_word;
				hold_valid <= 1'b1;
			end else if (tx_from_hold || tx_abort)
				hold_valid <= 1'b0;
			// set beats the software clear when both land together
			if (tx_direct || tx_from_hold || tx_abort)
				transmit_empty_flag <= 1'b1;
			else if (seq_wr)
				transmit_empty_flag <= 1'b0;
			if (frame_done || tx_abort)
				transmitter_idle_flag <= 1'b1;
			else if (seq_wr)
				transmitter_idle_flag <= 1'b0;
		end
	end

	// ==================================================================
	// receiver: pin synchroniser, then sixteen-tick recovery
	logic rx_meta;
	logic rx_sync;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			rx_meta <= rx_pin;
			rx_sync <= rx_meta;
		end
	end

	uftrx_rx_t rx_state;
	logic [3:0] rx_os;
	logic [3:0] rx_idx;
	logic [8:0] rx_shift;
	logic samp_a;
	logic samp_b;
	logic rx_noise;

	// three samples around mid-bit; two of three decide the level
	wire rx_vote_t = os_tick && rx_os == OS_VOTE;
	wire rx_bit = (samp_a & samp_b) | (samp_a & rx_sync)
		| (samp_b & rx_sync);
	wire rx_disagree = !(samp_a == samp_b && samp_b == rx_sync);
	wire rx_stop_t = rx_state == UFTRX_R_STOP && rx_vote_t;
	wire [8:0] rx_word = word_length_select ? rx_shift
		: {1'b0, rx_shift[8:1]};
	wire rx_parity_error_flag = parity_on && uftrx_word(rx_word, word_length_select,
		parity_on, parity_type_select) != rx_word;
	wire rx_addr = addr_detect_on && (word_length_select ? rx_word[8]
		: rx_word[7]);

	always_ff @(posedge sys_clk) begin
		if (clr || !receiver_on) begin
			rx_state <= UFTRX_R_IDLE;
			rx_os <= 4'h0;
			rx_idx <= 4'h0;
			rx_shift <= 9'h000;
			samp_a <= 1'b1;
			samp_b <= 1'b1;
			rx_noise <= 1'b0;
		end else begin
			if (os_tick)
				rx_os <= rx_os + 4'h1;
			if (os_tick && rx_os == OS_SAMPLE_A)
				samp_a <= rx_sync;
			if (os_tick && rx_os == OS_SAMPLE_B)
				samp_b <= rx_sync;
			if (rx_vote_t && rx_disagree)
				rx_noise <= 1'b1;
			case (rx_state)
				UFTRX_R_IDLE: begin
					rx_os <= 4'h0;
					rx_idx <= 4'h0;
					rx_noise <= 1'b0;
					if (!rx_sync)
						rx_state <= UFTRX_R_START;
				end
				UFTRX_R_START: begin
					if (rx_vote_t && rx_bit)
						rx_state <= UFTRX_R_IDLE; // false start
					else if (os_tick && rx_os == OS_LAST)
						rx_state <= UFTRX_R_DATA;
				end
				UFTRX_R_DATA: begin
					if (rx_vote_t)
						rx_shift <= {rx_bit, rx_shift[8:1]};
					if (os_tick && rx_os == OS_LAST) begin
						rx_idx <= rx_idx + 4'h1;
						if (rx_idx == tx_nbits - 4'h1)
							rx_state <= UFTRX_R_STOP;
					end
				end
				UFTRX_R_STOP: begin
					// only one stop bit is checked whatever is selected
					if (rx_vote_t)
						rx_state <= rx_bit ? UFTRX_R_IDLE
							: UFTRX_R_WAIT;
				end
				UFTRX_R_WAIT: begin
					if (rx_sync)
						rx_state <= UFTRX_R_IDLE;
				end
				default: rx_state <= UFTRX_R_IDLE;
			endcase
		end
	end

	// ==================================================================
	// receive buffer, four words of nine bits
	logic [8:0] rx_fifo [0:3];
	logic [1:0] wr_ptr;
	logic [1:0] rd_ptr;
	logic [2:0] receive_byte_count;

	wire fifo_room = receive_byte_count < FIFO_FULL;
	wire push = rx_stop_t && fifo_room;
	wire lost = rx_stop_t && !fifo_room;
	wire pop = rd_data && receive_byte_count != 3'h0;
	wire [2:0] next_count = receive_byte_count + {2'b00, push}
		- {2'b00, pop};
	wire [2:0] trig = receive_trigger_level == 2'h0 ? FIFO_FULL
		: {1'b0, receive_trigger_level};
	wire reach = next_count >= trig;
	// an empty buffer reads zero rather than an unwritten slot
	wire [8:0] head = receive_byte_count != 3'h0 ? rx_fifo[rd_ptr]
		: 9'h000;

	always_ff @(posedge sys_clk) begin
		if (push)
			rx_fifo[wr_ptr] <= rx_word;
	end

	always_ff @(posedge sys_clk) begin
		if (clr || unit_rise) begin
			wr_ptr <= 2'h0;
			rd_ptr <= 2'h0;
			receive_byte_count <= 3'h0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 2'h1;
			if (pop)
				rd_ptr <= rd_ptr + 2'h1;
			receive_byte_count <= next_count;
		end
	end

	// receive flags; a new event wins over the clearing read
	always_ff @(posedge sys_clk) begin
		if (clr) begin
			receive_available_flag <= 1'b0;
			overrun_flag <= 1'b0;
			framing_error_flag <= 1'b0;
			noise_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			receiver_idle_flag <= 1'b1;
			address_seen <= 1'b0;
		end else begin
			if (push && reach)
				receive_available_flag <= 1'b1;
			else if (seq_rd && !reach)
				receive_available_flag <= 1'b0;
			if (lost)
				overrun_flag <= 1'b1;
			else if (seq_rd)
				overrun_flag <= 1'b0;
			if (push && !rx_bit)
				framing_error_flag <= 1'b1;
			else if (seq_rd)
				framing_error_flag <= 1'b0;
			if (push && (rx_noise || rx_disagree))
				noise_flag <= 1'b1;
			else if (seq_rd)
				noise_flag <= 1'b0;
			if (push && rx_parity_error_flag)
				parity_error_flag <= 1'b1;
			else if (seq_rd)
				parity_error_flag <= 1'b0;
			if (push)
				address_seen <= rx_addr;
			if (rx_state == UFTRX_R_IDLE && !rx_sync && receiver_on)
				receiver_idle_flag <= 1'b0;
			else if (rx_stop_t || !receiver_on)
				receiver_idle_flag <= 1'b1;
		end
	end

	// ==================================================================
	// read data, one cycle after the read strobe; else zero
	wire [7:0] status_word = {parity_error_flag, noise_flag,
		framing_error_flag, overrun_flag, receiver_idle_flag,
		receive_available_flag, transmitter_idle_flag,
		transmit_empty_flag};
	wire [7:0] c1_word = {ctrl_one[7:2], head[8], ctrl_one[0]};
	wire [7:0] rd_mux = reg_addr == ADDR_CTRL_ONE ? c1_word
		: reg_addr == ADDR_CTRL_TWO ? ctrl_two
		: reg_addr == ADDR_STATUS ? status_word
		: reg_addr == ADDR_DATA ? head[7:0]
		: reg_addr == ADDR_DIV_HIGH ? baud_divisor[15:8]
		: reg_addr == ADDR_DIV_LOW ? baud_divisor[7:0]
		: reg_addr == ADDR_RX_COUNT ? {address_seen, 4'h0,
			receive_byte_count}
		: 8'h00;
	// break frames hold back the transmit-empty request
	wire next_irq = (transmit_empty_flag && ctrl_two[C2_TE_IRQ]
		&& tx_state != UFTRX_T_BREAK)
		|| ((receive_available_flag || overrun_flag)
		&& ctrl_two[C2_RX_IRQ]);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			irq_request <= 1'b0;
		end else begin
			reg_rdata <= reg_read ? rd_mux : 8'h00;
			irq_request <= next_irq;
		end
	end
endmodule : uftrx_core
`default_nettype wire

// *** uftrx_core_asserts.sv ***
`default_nettype none
// ==========================================================
// port checks for the serial frame core
module uftrx_core_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [2:0] reg_addr,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic tx_pin,
	input wire logic irq_request
);
	import uftrx_pkg::*;
	// line rests high through and just after reset
	property p_line_reset;
		@(posedge sys_clk) rst |=> tx_pin;
	endproperty
	a_line_reset: assert property (p_line_reset)
		else $error("tx line low after a reset edge");
	property p_line_release;
		@(posedge sys_clk) $fell(rst) |-> tx_pin [*2];
	endproperty
	a_line_release: assert property (p_line_release)
		else $error("tx line left idle level at reset release");
	property p_irq_reset;
		@(posedge sys_clk) rst |=> !irq_request;
	endproperty
	a_irq_reset: assert property (p_irq_reset)
		else $error("irq raised out of reset");
	// read data stands only in the cycle after a read strobe
	property p_rdata_quiet;
		@(posedge sys_clk) disable iff (rst)
			!reg_read |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_quiet: assert property (p_rdata_quiet)
		else $error("read data not zero without a read");
	property p_unmapped;
		@(posedge sys_clk) disable iff (rst)
			reg_read && reg_addr == 3'h7 |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped slot read nonzero");
	// both idle flags and the empty flag are up straight after reset
	property p_status_reset;
		@(posedge sys_clk) $fell(rst) && reg_read
			&& reg_addr == ADDR_STATUS |=> reg_rdata == 8'h0B;
	endproperty
	a_status_reset: assert property (p_status_reset)
		else $error("status after reset wrong");
	property p_count_range;
		@(posedge sys_clk) disable iff (rst)
			reg_read && reg_addr == ADDR_RX_COUNT |=>
			reg_rdata[6:3] == 4'h0 && reg_rdata[2:0] <= FIFO_FULL;
	endproperty
	a_count_range: assert property (p_count_range)
		else $error("receive count out of range");
	// a start bit holds the line low for at least eight clocks
	property p_start_len;
		@(posedge sys_clk) disable iff (rst)
			$fell(tx_pin) |-> !tx_pin [*8];
	endproperty
	a_start_len: assert property (p_start_len)
		else $error("start bit too short");
endmodule : uftrx_core_chk
bind uftrx_core uftrx_core_chk chk_u (.sys_clk, .rst, .reg_addr,
	.reg_read, .reg_rdata, .tx_pin, .irq_request);
`default_nettype wire

// *** uftrx_pkg.sv ***
`default_nettype none
// ==================================================================
// shared constants for the serial frame core
package uftrx_pkg;
	// register offsets on the plain register port
	localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
	localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
	localparam logic [2:0] ADDR_STATUS = 3'h2;
	localparam logic [2:0] ADDR_DATA = 3'h3;
	localparam logic [2:0] ADDR_DIV_HIGH = 3'h4;
	localparam logic [2:0] ADDR_DIV_LOW = 3'h5;
	localparam logic [2:0] ADDR_RX_COUNT = 3'h6;
	// serial_control_one fields
	localparam int C1_UNIT_ON = 7;
	localparam int C1_WORD_LEN = 6;
	localparam int C1_PARITY_ON = 5;
	localparam int C1_PTYPE_LO = 3;
	localparam int C1_STOP_CNT = 2;
	localparam int C1_RX_NINTH = 1;
	localparam int C1_TX_NINTH = 0;
	// serial_control_two fields
	localparam int C2_TX_ON = 7;
	localparam int C2_RX_ON = 6;
	localparam int C2_BREAK = 5;
	localparam int C2_ADDR_ON = 4;
	localparam int C2_TE_IRQ = 3;
	localparam int C2_RX_IRQ = 2;
	localparam int C2_TRIG_LO = 0;
	// reset values
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h0000;
	// parity type codes
	localparam logic [1:0] PAR_EVEN = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_MARK = 2'h2;
	// oversampling and frame figures
	localparam logic [3:0] OS_LAST = 4'hF;
	localparam logic [3:0] OS_SAMPLE_A = 4'h7;
	localparam logic [3:0] OS_SAMPLE_B = 4'h8;
	localparam logic [3:0] OS_VOTE = 4'h9;
	localparam logic [3:0] BREAK_BITS = 4'hD;
	localparam logic [2:0] FIFO_FULL = 3'h4;
	typedef enum logic [2:0] {
		UFTRX_T_IDLE = 3'b000,
		UFTRX_T_START = 3'b001,
		UFTRX_T_DATA = 3'b010,
		UFTRX_T_STOP = 3'b011,
		UFTRX_T_BREAK = 3'b100
	} uftrx_tx_t;
	typedef enum logic [2:0] {
		UFTRX_R_IDLE = 3'b000,
		UFTRX_R_START = 3'b001,
		UFTRX_R_DATA = 3'b010,
		UFTRX_R_STOP = 3'b011,
		UFTRX_R_WAIT = 3'b100
	} uftrx_rx_t;
endpackage : uftrx_pkg
`default_nettype wire

// *** uftrx_remote.sv ***
`default_nettype none
// ==========================================================
// far-side serial device, sixteen clocks a bit (divisor 0)
module uftrx_remote (
	input wire logic sys_clk,
	input wire logic tx_pin,
	output logic rx_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT = 16;
	int nbits = 8;
	int stop_bad = 0;
	logic [8:0] word;
	logic [8:0] got_q[$];
	time t_q[$];
	initial rx_pin = 1'b1;
	// centre-sample each bit, lsb first; a low stop counts as a fault
	always begin
		@(negedge tx_pin);
		t_q.push_back($time);
		repeat (BIT / 2) @(posedge sys_clk);
		word = 9'h000;
		for (int i = 0; i < nbits; i++) begin
			repeat (BIT) @(posedge sys_clk);
			word[i] = tx_pin;
		end
		repeat (BIT) @(posedge sys_clk);
		if (tx_pin !== 1'b1)
			stop_bad++;
		got_q.push_back(word);
	end
	// one frame, one clock of noise inside bit glitch, then idle high
	task automatic send(input logic [8:0] w, input int n,
		input logic stop, input int glitch);
		rx_pin <= 1'b0;
		repeat (BIT) @(posedge sys_clk);
		for (int i = 0; i < n; i++) begin
			rx_pin <= w[i];
			repeat (10) @(posedge sys_clk);
			if (i == glitch)
				rx_pin <= ~w[i];
			@(posedge sys_clk);
			rx_pin <= w[i];
			repeat (5) @(posedge sys_clk);
		end
		rx_pin <= stop;
		repeat (BIT) @(posedge sys_clk);
		rx_pin <= 1'b1;
		repeat (BIT) @(posedge sys_clk);
	endtask : send
endmodule : uftrx_remote
`default_nettype wire
